// >>> clt_pkg.sv
// package: register map, mode codes, reset values and limits of the channel level trigger
package clt_pkg;

   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [15:0] CLT_ADDR_TRIGGER_LEVEL_COUNT = 16'h09C4;
   localparam logic [15:0] CLT_ADDR_GLOBAL_TRIGGER_MODE = 16'h9C40;
   localparam logic [15:0] CLT_ADDR_CH0_TRIGGER_MODE    = 16'h9D08;
   localparam logic [15:0] CLT_ADDR_CH0_UPPER_LEVEL     = 16'hA410;
   localparam logic [15:0] CLT_ADDR_CH0_LOWER_LEVEL     = 16'hA474;
   localparam logic [15:0] CLT_ADDR_PULSE_WIDTH_SAMPLES = 16'hABE0;

   // ****************************************
   // mode codes
   // ****************************************
   localparam logic [31:0] CLT_PER_CHANNEL_TRIGGER_SELECT = 32'h0000_4E48; // 20040
   localparam logic [31:0] CLT_RISING_EDGE_MODE           = 32'h0000_2710; // 10000
   localparam logic [31:0] CLT_LONG_HIGH_PULSE_MODE       = 32'h0000_2711; // 10001
   localparam logic [31:0] CLT_SHORT_HIGH_PULSE_MODE      = 32'h0000_2712; // 10002
   localparam logic [31:0] CLT_FALLING_EDGE_MODE          = 32'h0000_271A; // 10010
   localparam logic [31:0] CLT_LONG_LOW_PULSE_MODE        = 32'h0000_271B; // 10011
   localparam logic [31:0] CLT_SHORT_LOW_PULSE_MODE       = 32'h0000_271C; // 10012
   localparam logic [31:0] CLT_CHANNEL_DETECT_DISABLED    = 32'h0000_2724; // 10020
   localparam logic [31:0] CLT_DUAL_EDGE_MODE             = 32'h0000_272E; // 10030
   localparam logic [31:0] CLT_WINDOW_ENTER_MODE          = 32'h0000_2738; // 10040
   localparam logic [31:0] CLT_LONG_INSIDE_WINDOW_MODE    = 32'h0000_2739; // 10041
   localparam logic [31:0] CLT_WINDOW_EXIT_MODE           = 32'h0000_2742; // 10050

   // ****************************************
   // reset values and limits
   // ****************************************
   localparam logic [31:0] CLT_RST_GLOBAL_MODE  = 32'h0000_0000;
   localparam logic [31:0] CLT_RST_CH_MODE      = CLT_CHANNEL_DETECT_DISABLED;
   localparam logic [31:0] CLT_RST_LEVEL        = 32'h0000_0000;
   localparam logic [7:0]  CLT_RST_PULSE_WIDTH  = 8'h02;
   localparam logic [7:0]  CLT_PULSE_WIDTH_MIN  = 8'h02;

   typedef enum logic [1:0] {CLT_CMP_BELOW, CLT_CMP_INSIDE, CLT_CMP_ABOVE} clt_zone_t;

endpackage

// >>> clt_classify.sv
// module: classifies one sample against the upper and lower levels
`timescale 1ns/1ps
module clt_classify
   import clt_pkg::*;
#(
   parameter int LEVEL_BITS = 8
)
(
   input  wire logic signed [LEVEL_BITS-1:0] sample_top,
   input  wire logic signed [LEVEL_BITS-1:0] upper_level,
   input  wire logic signed [LEVEL_BITS-1:0] lower_level,
   output logic                              above_upper,
   output logic                              in_window
);

   // signed compare on the truncated sample
   assign above_upper = sample_top > upper_level;
   assign in_window   = (sample_top >= lower_level) && (sample_top <= upper_level);

endmodule

// >>> clt_channel_level_trigger.sv
// module: per-channel level trigger with register port
`timescale 1ns/1ps

// Operation
// - read-only register reports number of usable trigger levels, 255 for 8 bits.
// - rising-edge mode triggers when samples cross the upper level upward.
// - falling-edge mode triggers when samples cross the upper level downward.
// - dual-edge mode triggers on a crossing in either direction.
// - pulse modes start the counter on a crossing in the configured direction.
// - long-pulse modes trigger when the count completes without an opposite crossing.
// - long-pulse modes suppress the trigger on an early opposite crossing.
// - short-pulse modes trigger when the level is recrossed before the count completes.
// - short-pulse modes give no trigger when the count completes uninterrupted.
// - window-enter mode triggers each time samples move from outside to inside.
// - window-exit mode triggers each time samples move from inside to outside.
// - long-inside mode counts from entry and triggers if still inside at expiry.
// - long-inside mode cancels without trigger when samples leave early.
// - upper N sample bits compared with N-bit levels as signed numbers.
// - the most negative level code is never used.
module clt_channel_level_trigger
   import clt_pkg::*;
#(
   parameter int SAMPLE_BITS = 16,
   parameter int LEVEL_BITS  = 8,
   parameter int WIDTH_BITS  = 8
)
(
   input  wire logic                          clk,
   input  wire logic                          reset,
   input  wire logic [15:0]                   reg_addr,
   input  wire logic [31:0]                   reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output logic      [31:0]                   reg_rdata,
   input  wire logic signed [SAMPLE_BITS-1:0] sample_data,
   input  wire logic                          sample_valid,
   output logic                               trigger_pulse
);

   // ****************************************
   // elaboration checks
   // ****************************************
   // refused while elaborating, so a bad width never reaches simulation
   if (LEVEL_BITS < 2 || LEVEL_BITS > SAMPLE_BITS || LEVEL_BITS > 31)
      $error("clt: LEVEL_BITS out of range");
   if (WIDTH_BITS < 2 || WIDTH_BITS > 31)
      $error("clt: WIDTH_BITS out of range");

   localparam logic [31:0] LEVEL_COUNT = 32'((64'd1 << LEVEL_BITS) - 64'd1);
   localparam logic signed [LEVEL_BITS-1:0] LEVEL_MIN =
      {1'b1, {(LEVEL_BITS-1){1'b0}}} + LEVEL_BITS'(1);

   // ****************************************
   // registers
   // ****************************************
   logic        [31:0]           global_mode_r;
   logic        [31:0]           ch_mode_r;
   logic signed [LEVEL_BITS-1:0] upper_r;
   logic signed [LEVEL_BITS-1:0] lower_r;
   logic        [WIDTH_BITS-1:0] width_r;
   logic                         cfg_touch;
   logic signed [LEVEL_BITS-1:0] wlevel;
   logic        [WIDTH_BITS-1:0] wwidth;

   // clamp the written level so the most negative code never reaches the comparator
   always_comb
   begin
      wlevel = reg_wdata[LEVEL_BITS-1:0];
      if (wlevel == {1'b1, {(LEVEL_BITS-1){1'b0}}})
         wlevel = LEVEL_MIN;
      wwidth = reg_wdata[WIDTH_BITS-1:0];
      if (wwidth < WIDTH_BITS'(CLT_PULSE_WIDTH_MIN))
         wwidth = WIDTH_BITS'(CLT_PULSE_WIDTH_MIN);
   end

   assign cfg_touch = reg_wr && (reg_addr == CLT_ADDR_CH0_TRIGGER_MODE
                                 || reg_addr == CLT_ADDR_CH0_UPPER_LEVEL
                                 || reg_addr == CLT_ADDR_CH0_LOWER_LEVEL
                                 || reg_addr == CLT_ADDR_PULSE_WIDTH_SAMPLES
                                 || reg_addr == CLT_ADDR_GLOBAL_TRIGGER_MODE);

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         global_mode_r <= CLT_RST_GLOBAL_MODE;
         ch_mode_r     <= CLT_RST_CH_MODE;
         upper_r       <= LEVEL_BITS'(CLT_RST_LEVEL);
         lower_r       <= LEVEL_BITS'(CLT_RST_LEVEL);
         width_r       <= WIDTH_BITS'(CLT_RST_PULSE_WIDTH);
      end
      else if (reg_wr)
      begin
         unique case (reg_addr)
            CLT_ADDR_GLOBAL_TRIGGER_MODE: global_mode_r <= reg_wdata;
            CLT_ADDR_CH0_TRIGGER_MODE:    ch_mode_r     <= reg_wdata;
            CLT_ADDR_CH0_UPPER_LEVEL:     upper_r       <= wlevel;
            CLT_ADDR_CH0_LOWER_LEVEL:     lower_r       <= wlevel;
            CLT_ADDR_PULSE_WIDTH_SAMPLES: width_r       <= wwidth;
            default: ;
         endcase
      end
   end

   // ****************************************
   // read port
   // ****************************************
   logic [31:0] rd_nxt;

   always_comb
   begin
      unique case (reg_addr)
         CLT_ADDR_TRIGGER_LEVEL_COUNT: rd_nxt = LEVEL_COUNT;
         CLT_ADDR_GLOBAL_TRIGGER_MODE: rd_nxt = global_mode_r;
         CLT_ADDR_CH0_TRIGGER_MODE:    rd_nxt = ch_mode_r;
         CLT_ADDR_CH0_UPPER_LEVEL:     rd_nxt = 32'(upper_r);
         CLT_ADDR_CH0_LOWER_LEVEL:     rd_nxt = 32'(lower_r);
         CLT_ADDR_PULSE_WIDTH_SAMPLES: rd_nxt = 32'(width_r);
         default:                      rd_nxt = 32'h0000_0000;
      endcase
   end

   // read data valid the cycle after the strobe only
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         reg_rdata <= 32'h0000_0000;
      else if (reg_rd)
         reg_rdata <= (reg_addr == CLT_ADDR_CH0_TRIGGER_MODE)
                      ? {ch_mode_r[31:1] & 31'h7FFF_FFFF, ch_mode_r[0]} : rd_nxt;
      else
         reg_rdata <= 32'h0000_0000;
   end

   // ****************************************
   // sample classification
   // ****************************************
   logic signed [LEVEL_BITS-1:0] sample_top;
   logic                         above_now;
   logic                         inside_now;
   logic                         above_prev_r;
   logic                         inside_prev_r;
   logic                         prev_ok_r;

   assign sample_top = sample_data[SAMPLE_BITS-1 -: LEVEL_BITS];

   clt_classify #(
      .LEVEL_BITS (LEVEL_BITS)
   ) u_classify (
      .sample_top  (sample_top),
      .upper_level (upper_r),
      .lower_level (lower_r),
      .above_upper (above_now),
      .in_window   (inside_now)
   );

   logic active;
   logic rise_x;
   logic fall_x;
   logic enter_x;
   logic leave_x;

   // per-channel modes only act when the global selector picks them
   assign active  = (global_mode_r == CLT_PER_CHANNEL_TRIGGER_SELECT) && sample_valid;
   assign rise_x  = prev_ok_r && !above_prev_r && above_now;
   assign fall_x  = prev_ok_r && above_prev_r && !above_now;
   assign enter_x = prev_ok_r && !inside_prev_r && inside_now;
   assign leave_x = prev_ok_r && inside_prev_r && !inside_now;

   // history is dropped on a config write so no stale crossing fires
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         above_prev_r  <= 1'b0;
         inside_prev_r <= 1'b0;
         prev_ok_r     <= 1'b0;
      end
      else if (cfg_touch)
         prev_ok_r <= 1'b0;
      else if (active)
      begin
         above_prev_r  <= above_now;
         inside_prev_r <= inside_now;
         prev_ok_r     <= 1'b1;
      end
   end

   // ****************************************
   // pulse-width detector
   // ****************************************
   logic                  arm_x;
   logic                  stop_x;
   logic                  is_long;
   logic                  is_short;
   logic                  is_win_long;
   logic                  counting_r;
   logic [WIDTH_BITS-1:0] count_r;
   logic                  expire;

   assign is_long     = ch_mode_r == CLT_LONG_HIGH_PULSE_MODE
                        || ch_mode_r == CLT_LONG_LOW_PULSE_MODE;
   assign is_short    = ch_mode_r == CLT_SHORT_HIGH_PULSE_MODE
                        || ch_mode_r == CLT_SHORT_LOW_PULSE_MODE;
   assign is_win_long = ch_mode_r == CLT_LONG_INSIDE_WINDOW_MODE;

   always_comb
   begin
      arm_x  = 1'b0;
      stop_x = 1'b0;
      if (ch_mode_r == CLT_LONG_HIGH_PULSE_MODE || ch_mode_r == CLT_SHORT_HIGH_PULSE_MODE)
      begin
         arm_x  = rise_x;
         stop_x = fall_x;
      end
      else if (ch_mode_r == CLT_LONG_LOW_PULSE_MODE || ch_mode_r == CLT_SHORT_LOW_PULSE_MODE)
      begin
         arm_x  = fall_x;
         stop_x = rise_x;
      end
      else if (is_win_long)
      begin
         arm_x  = enter_x;
         stop_x = leave_x;
      end
   end

   // counter reaches width samples after the arming sample
   assign expire = counting_r && !stop_x && (count_r + WIDTH_BITS'(1) >= width_r);

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         counting_r <= 1'b0;
         count_r    <= '0;
      end
      else if (cfg_touch)
      begin
         counting_r <= 1'b0;
         count_r    <= '0;
      end
      else if (active)
      begin
         if (!counting_r && arm_x)
         begin
            counting_r <= 1'b1;
            count_r    <= '0;
         end
         else if (counting_r && (stop_x || expire))
            counting_r <= 1'b0;
         else if (counting_r)
            count_r <= count_r + WIDTH_BITS'(1);
      end
   end

   // ****************************************
   // trigger decision
   // ****************************************
   logic hit;

   always_comb
   begin
      hit = 1'b0;
      unique case (1'b1)
         ch_mode_r == CLT_RISING_EDGE_MODE:  hit = rise_x;
         ch_mode_r == CLT_FALLING_EDGE_MODE: hit = fall_x;
         ch_mode_r == CLT_DUAL_EDGE_MODE:    hit = rise_x || fall_x;
         ch_mode_r == CLT_WINDOW_ENTER_MODE: hit = enter_x;
         ch_mode_r == CLT_WINDOW_EXIT_MODE:  hit = leave_x;
         is_long:                            hit = expire;
         is_win_long:                        hit = expire;
         is_short:                           hit = counting_r && stop_x;
         default:                            hit = 1'b0;
      endcase
   end

   // registered so each event is exactly one clock wide
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         trigger_pulse <= 1'b0;
      else
         trigger_pulse <= active && !cfg_touch && hit;
   end

endmodule

// >>> clt_monitor.sv
// checker: port-level assertions for the channel level trigger
`timescale 1ns/1ps
module clt_monitor
   import clt_pkg::*;
#(
   parameter int SAMPLE_BITS = 16
)
(
   input wire logic                          clk,
   input wire logic                          reset,
   input wire logic [15:0]                   reg_addr,
   input wire logic [31:0]                   reg_wdata,
   input wire logic                          reg_wr,
   input wire logic                          reg_rd,
   input wire logic [31:0]                   reg_rdata,
   input wire logic signed [SAMPLE_BITS-1:0] sample_data,
   input wire logic                          sample_valid,
   input wire logic                          trigger_pulse
);
   // ****
   // shadow of the configuration and sample history
   // ****
   logic signed [7:0] up_r, lo_r, pv_r, cur;
   logic [31:0]       md_r, gl_r;
   logic              hv_r, cfg, ok, pin, cin;

   function automatic logic signed [7:0] clamp(input logic [7:0] v);
      return (v == 8'h80) ? 8'h81 : v;
   endfunction

   assign cur = sample_data[SAMPLE_BITS-1 -: 8];
   assign cfg = reg_wr && (reg_addr inside {CLT_ADDR_GLOBAL_TRIGGER_MODE,
      CLT_ADDR_CH0_TRIGGER_MODE, CLT_ADDR_CH0_UPPER_LEVEL, CLT_ADDR_CH0_LOWER_LEVEL,
      CLT_ADDR_PULSE_WIDTH_SAMPLES});
   assign ok  = gl_r == CLT_PER_CHANNEL_TRIGGER_SELECT && sample_valid && hv_r && !cfg;
   assign pin = pv_r >= lo_r && pv_r <= up_r;
   assign cin = cur >= lo_r && cur <= up_r;

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         gl_r <= CLT_RST_GLOBAL_MODE;
         md_r <= CLT_RST_CH_MODE;
         up_r <= 8'h00;
         lo_r <= 8'h00;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            CLT_ADDR_GLOBAL_TRIGGER_MODE: gl_r <= reg_wdata;
            CLT_ADDR_CH0_TRIGGER_MODE:    md_r <= reg_wdata;
            CLT_ADDR_CH0_UPPER_LEVEL:     up_r <= clamp(reg_wdata[7:0]);
            CLT_ADDR_CH0_LOWER_LEVEL:     lo_r <= clamp(reg_wdata[7:0]);
            default: ;
         endcase
      end
   end

   // a config write forgets the previous sample, so no crossing is seen next
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         hv_r <= 1'b0;
      else if (cfg)
         hv_r <= 1'b0;
      else if (sample_valid)
         hv_r <= 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (sample_valid)
         pv_r <= cur;
   end

   // ****
   // assertions
   // ****
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // back-to-back samples may legally give back-to-back events
   property p_one; trigger_pulse && !sample_valid |=> !trigger_pulse; endproperty
   a_one: assert property (p_one)
      else $error("trigger pulse longer than one cycle");
   property p_valid; trigger_pulse |-> $past(sample_valid); endproperty
   a_valid: assert property (p_valid)
      else $error("trigger pulse without a sample before it");
   property p_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
   a_idle: assert property (p_idle)
      else $error("read data not zero outside read answer");
   property p_cnt; reg_rd && reg_addr == CLT_ADDR_TRIGGER_LEVEL_COUNT
      |=> reg_rdata == 32'h0000_00FF; endproperty
   a_cnt: assert property (p_cnt)
      else $error("level count read wrong");
   property p_rise; ok && md_r == CLT_RISING_EDGE_MODE && !(pv_r > up_r) && cur > up_r
      |=> trigger_pulse; endproperty
   a_rise: assert property (p_rise)
      else $error("rising crossing missed");
   property p_fall; ok && md_r == CLT_FALLING_EDGE_MODE && pv_r > up_r && !(cur > up_r)
      |=> trigger_pulse; endproperty
   a_fall: assert property (p_fall)
      else $error("falling crossing missed");
   property p_enter; ok && md_r == CLT_WINDOW_ENTER_MODE && !pin && cin
      |=> trigger_pulse; endproperty
   a_enter: assert property (p_enter)
      else $error("window entry missed");
   property p_exit; ok && md_r == CLT_WINDOW_EXIT_MODE && pin && !cin
      |=> trigger_pulse; endproperty
   a_exit: assert property (p_exit)
      else $error("window exit missed");
   property p_off; gl_r != CLT_PER_CHANNEL_TRIGGER_SELECT
      || md_r == CLT_CHANNEL_DETECT_DISABLED |=> !trigger_pulse; endproperty
   a_off: assert property (p_off)
      else $error("trigger while detection disabled");
endmodule

bind clt_channel_level_trigger clt_monitor #(.SAMPLE_BITS(SAMPLE_BITS)) mon_u (
   .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_data(sample_data),
   .sample_valid(sample_valid), .trigger_pulse(trigger_pulse));

// >>> clt_adc_model.sv
// partner: adc front end, one registered sample word per requested clock
`timescale 1ns/1ps
module clt_adc_model
(
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic signed [7:0] level_in,
   input  wire logic              fire,
   output logic signed [15:0]     sample_data,
   output logic                   sample_valid
);
   // ****
   // sample drive
   // ****
   // low byte is noise, only the top byte may decide; idle words keep toggling
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         sample_data <= 16'h0000;
      else if (fire)
         sample_data <= {level_in, 8'hA5};
      else
         sample_data <= ~sample_data;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         sample_valid <= 1'b0;
      else
         sample_valid <= fire;
   end
endmodule

// >>> clt_channel_level_trigger_test.sv
// testbench: register and trigger-mode scenarios for the channel level trigger
`timescale 1ns/1ps
module clt_channel_level_trigger_test
   import clt_pkg::*;
();
   logic               clk, reset, reg_wr, reg_rd, fire, sample_valid, trigger_pulse;
   logic [15:0]        reg_addr;
   logic [31:0]        reg_wdata, reg_rdata;
   logic signed [7:0]  lvl;
   logic signed [15:0] sample_data;
   int                 miscompares, n_checks, ntrig;

   clt_channel_level_trigger dut_u (.clk(clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .sample_data(sample_data), .sample_valid(sample_valid), .trigger_pulse(trigger_pulse));
   clt_adc_model adc_u (.clk(clk), .reset(reset), .level_in(lvl), .fire(fire),
      .sample_data(sample_data), .sample_valid(sample_valid));

   always #4 clk = ~clk;
   always @(posedge clk)
   begin
      if (trigger_pulse === 1'b1)
         ntrig++;
   end

   // ****
   // tasks
   // ****
   task automatic test_done;
      if (miscompares == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // each access is a strobe cycle then a quiet cycle, so no strobe is set twice
   task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d,
                      input logic [31:0] exp, input string nm);
      reg_wr    <= w;
      reg_rd    <= !w;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1;
      if (!w)
         chk(nm, reg_rdata, exp);
      @(posedge clk);
   endtask

   // samples right-aligned in vv; a quiet cycle after every second one
   task automatic seq(input logic [31:0] m, input int n, input logic [63:0] vv,
                      input int exp, input string nm);
      acc(1'b1, CLT_ADDR_CH0_TRIGGER_MODE, m, 32'h0, "");
      ntrig = 0;
      for (int i = 0; i < n; i++)
      begin
         lvl  <= vv[8*(n-1-i) +: 8];
         fire <= 1'b1;
         @(posedge clk);
         if (i % 2 == 1)
         begin
            fire <= 1'b0;
            @(posedge clk);
         end
      end
      fire <= 1'b0;
      repeat (5) @(posedge clk);
      chk(nm, ntrig, exp);
   endtask

   // ****
   // main sequence
   // ****
   initial
   begin
      clk = 1'b0;
      reset = 1'b1;
      {reg_wr, reg_rd, fire, lvl, reg_addr, reg_wdata} = '0;
      {miscompares, n_checks, ntrig} = '0;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      acc(0, CLT_ADDR_TRIGGER_LEVEL_COUNT, 0, 32'h0000_00FF, "lvl count");
      acc(0, CLT_ADDR_GLOBAL_TRIGGER_MODE, 0, CLT_RST_GLOBAL_MODE, "glb rst");
      acc(0, CLT_ADDR_CH0_TRIGGER_MODE, 0, CLT_RST_CH_MODE, "mode rst");
      acc(0, CLT_ADDR_CH0_LOWER_LEVEL, 0, CLT_RST_LEVEL, "low rst");
      acc(0, CLT_ADDR_PULSE_WIDTH_SAMPLES, 0, {24'h0, CLT_RST_PULSE_WIDTH}, "pw rst");
      acc(1, CLT_ADDR_TRIGGER_LEVEL_COUNT, 32'h10, 0, "");
      acc(0, CLT_ADDR_TRIGGER_LEVEL_COUNT, 0, 32'h0000_00FF, "lvl ro");
      acc(0, 16'h0004, 0, 32'h0, "unmapped");
      acc(1, CLT_ADDR_CH0_UPPER_LEVEL, 32'h80, 0, "");
      acc(0, CLT_ADDR_CH0_UPPER_LEVEL, 0, 32'hFFFF_FF81, "up clamp");
      acc(1, CLT_ADDR_PULSE_WIDTH_SAMPLES, 32'h1, 0, "");
      acc(0, CLT_ADDR_PULSE_WIDTH_SAMPLES, 0, 32'h2, "pw clamp");
      acc(1, CLT_ADDR_CH0_UPPER_LEVEL, 32'h10, 0, "");
      acc(1, CLT_ADDR_CH0_LOWER_LEVEL, 32'hF0, 0, "");
      acc(0, CLT_ADDR_CH0_LOWER_LEVEL, 0, 32'hFFFF_FFF0, "low rd");
      acc(1, CLT_ADDR_PULSE_WIDTH_SAMPLES, 32'h3, 0, "");
      seq(CLT_RISING_EDGE_MODE, 4, 64'hE020E020, 0, "glb off");
      acc(1, CLT_ADDR_GLOBAL_TRIGGER_MODE, CLT_PER_CHANNEL_TRIGGER_SELECT, 0, "");
      seq(CLT_RISING_EDGE_MODE, 4, 64'hE020E020, 2, "rise");
      seq(CLT_FALLING_EDGE_MODE, 4, 64'hE020E020, 1, "fall");
      seq(CLT_DUAL_EDGE_MODE, 4, 64'hE020E020, 3, "dual");
      seq(CLT_LONG_HIGH_PULSE_MODE, 8, 64'hE020E02020202020, 1, "long hi");
      seq(CLT_LONG_LOW_PULSE_MODE, 8, 64'h20E020E0E0E0E0E0, 1, "long lo");
      seq(CLT_SHORT_HIGH_PULSE_MODE, 8, 64'hE020E020202020E0, 1, "short hi");
      seq(CLT_SHORT_LOW_PULSE_MODE, 8, 64'h20E020E0E0E0E020, 1, "short lo");
      seq(CLT_WINDOW_ENTER_MODE, 6, 64'hE0002000E000, 3, "enter");
      seq(CLT_WINDOW_EXIT_MODE, 6, 64'hE0002000E000, 2, "exit");
      seq(CLT_LONG_INSIDE_WINDOW_MODE, 8, 64'hE000E00000000000, 1, "inside");
      seq(CLT_CHANNEL_DETECT_DISABLED, 4, 64'hE020E020, 0, "ch off");
      test_done;
   end

   initial
   begin
      #20000;
      miscompares++;
      test_done;
   end
endmodule
